// ---- verilog/lsit_device.sv ----
// Sensor end: link slave, oscillator, integration sequencer and results
// Overview of operation
// RQ1 - Oscillator half rate low ranges, full high
// RQ2 - Command bit five selects external timing
// RQ3 - Internal mode integrates two-power cycle counts
// RQ4 - Width field in command bits one, zero
// RQ5 - Width 0..3 gives 2^16, 2^12, 2^8, 2^4
// RQ6 - Same oscillator rate in both modes
// RQ7 - Host sends three syncs; first starts array one
// RQ8 - Second sync switches to array two
// RQ9 - Third sync publishes and restarts array one
// RQ10 - Host spaces syncs at equal intervals
// RQ11 - External mode counts cycles, readable timer
// RQ12 - Cycle counter is sixteen bits wide
// RQ13 - Host keeps integration below counter range
// RQ14 - Result is first diode minus second
// RQ15 - Host retries zero reading at other range
// RQ16 - Timer latched per integration, low byte first
// RQ17 - Data register refreshed every integration
`timescale 1ns/1ps
module lsit_device (
   lsit_link_if.device link,
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic balancePulse,
   output logic irPhase,
   output logic resultValid,
   output logic [lsit_pkg::RESULT_W-1:0] ambientLightResult,
   output logic [lsit_pkg::TIMER_W-1:0] intervalCycleCount,
   output logic [lsit_pkg::BYTE_W-1:0] commandValue
);
   import lsit_pkg::*;

   logic [1:0] linkSync;
   logic sclNow;
   logic sdaNow;
   logic sclPrev;
   logic sdaPrev;
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;

   logic inFrame;
   logic [CNT_W-1:0] bitCount;
   logic [FRAME_BITS-1:0] shiftIn;
   logic writeDone;
   logic [ADDR_W-1:0] frameAddr;
   logic [BYTE_W-1:0] frameData;
   logic headerDone;
   logic [ADDR_W-1:0] readAddr;
   logic [BYTE_W-1:0] readValue;
   logic reading;
   logic [BYTE_W-1:0] readShift;

   logic [BYTE_W-1:0] commandReg;
   logic extMode;
   logic rangeHigh;
   logic syncCmd;

   logic [DIV_W-1:0] divCount;
   logic [DIV_W-1:0] divLimit;
   logic oscTick;

   lsit_dev_state_type state;
   logic modePrev;
   logic [PHASE_W-1:0] phaseCount;
   logic [PHASE_W-1:0] target;
   logic phaseEnd;
   logic advance;
   logic publish;
   logic [RESULT_W-1:0] accum;
   logic [RESULT_W-1:0] next_accum;
   logic [TIMER_W-1:0] timer;
   logic [TIMER_W-1:0] next_timer;

   // Link pins come from another clock domain
   lsit_sync #(
      .WIDTH(2),
      .RESET_VAL(2'h3)
   ) u_linkSync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .din({link.scl, link.sda}),
      .dout(linkSync)
   );

   assign sclNow = linkSync[1];
   assign sdaNow = linkSync[0];
   assign sclRise = sclNow & ~sclPrev;
   assign sclFall = ~sclNow & sclPrev;
   assign startSeen = sclNow & sclPrev & sdaPrev & ~sdaNow;
   assign stopSeen = sclNow & sclPrev & ~sdaPrev & sdaNow;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else begin
         sclPrev <= sclNow;
         sdaPrev <= sdaNow;
      end
   end

   // Frame receiver; a new start aborts any frame in progress
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         inFrame <= 1'b0;
         bitCount <= '0;
         shiftIn <= '0;
      end else if (startSeen) begin
         inFrame <= 1'b1;
         bitCount <= '0;
      end else if (stopSeen) begin
         inFrame <= 1'b0;
      end else if (inFrame && sclRise && bitCount != FRAME_BITS) begin
         shiftIn <= {shiftIn[FRAME_BITS-2:0], sdaNow};
         bitCount <= bitCount + 5'h01;
      end
   end

   // Writes act only on a complete frame closed by a stop
   assign writeDone = stopSeen & inFrame & (bitCount == FRAME_BITS) &
      ~shiftIn[FRAME_BITS-1];
   assign frameAddr = shiftIn[FRAME_BITS-2 -: ADDR_W];
   assign frameData = shiftIn[BYTE_W-1:0];
   assign syncCmd = writeDone & (frameAddr == REG_SYNC);
   assign headerDone = inFrame & sclRise & (bitCount == HDR_LAST);
   assign readAddr = {shiftIn[ADDR_W-2:0], sdaNow};

   always_comb begin
      case (readAddr)
         REG_COMMAND: readValue = commandReg;
         REG_DATA_LSB: readValue = ambientLightResult[BYTE_W-1:0];
         REG_DATA_MSB: readValue = ambientLightResult[RESULT_W-1 -: BYTE_W];
         REG_TIMER_LSB: readValue = intervalCycleCount[BYTE_W-1:0]; // RQ16
         REG_TIMER_MSB: readValue = intervalCycleCount[TIMER_W-1 -: BYTE_W];
         default: readValue = 8'h00;
      endcase
   end

   // Read data leaves on falling link clock, pulled low for zeros
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         reading <= 1'b0;
         readShift <= '0;
         link.sdaDevOe <= 1'b0;
      end else if (startSeen || stopSeen) begin
         reading <= 1'b0;
         link.sdaDevOe <= 1'b0;
      end else if (headerDone && shiftIn[ADDR_W-1]) begin
         reading <= 1'b1;
         readShift <= readValue;
      end else if (reading && sclFall) begin
         if (bitCount == FRAME_BITS) begin
            reading <= 1'b0;
            link.sdaDevOe <= 1'b0;
         end else begin
            link.sdaDevOe <= ~readShift[BYTE_W-1];
            readShift <= {readShift[BYTE_W-2:0], 1'b0};
         end
      end
   end

   assign link.sdaDevOut = 1'b0;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         commandReg <= CMD_RESET;
      end else if (writeDone && frameAddr == REG_COMMAND) begin
         commandReg <= frameData;
      end
   end

   assign commandValue = commandReg;
   assign extMode = commandReg[CMD_EXT_BIT]; // RQ2
   assign rangeHigh = commandReg[CMD_RANGE_MSB];

   // Divider is shared by both timing modes
   assign divLimit = rangeHigh ? OSC_FULL_DIV : OSC_HALF_DIV; // RQ1 RQ6
   assign oscTick = (divCount >= divLimit - 10'h001);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         divCount <= '0;
      end else if (oscTick) begin
         divCount <= '0;
      end else begin
         divCount <= divCount + 10'h001;
      end
   end

   always_comb begin
      case (commandReg[CMD_WIDTH_LSB +: CMD_WIDTH_W]) // RQ4
         2'h0: target = CYCLES_W0; // RQ5
         2'h1: target = CYCLES_W1;
         2'h2: target = CYCLES_W2;
         default: target = CYCLES_W3;
      endcase
   end

   // At or past the target, so narrowing the width mid-phase cannot hang
   assign phaseEnd = ~extMode & oscTick &
      (phaseCount >= target - 17'h0_0001); // RQ3
   assign advance = extMode ? syncCmd : phaseEnd;
   assign publish = (state == DEV_ARRAY2) & advance & (extMode == modePrev);

   // A mode change drops the run in progress and restarts cleanly
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state <= DEV_IDLE;
         modePrev <= 1'b0;
         phaseCount <= '0;
      end else begin
         modePrev <= extMode;
         if (extMode != modePrev) begin
            state <= DEV_IDLE;
            phaseCount <= '0;
         end else begin
            case (state)
               DEV_IDLE: begin
                  if (!extMode || syncCmd) begin // RQ7
                     state <= DEV_ARRAY1;
                     phaseCount <= '0;
                  end
               end
               DEV_ARRAY1: begin
                  if (advance) begin // RQ8
                     state <= DEV_ARRAY2;
                     phaseCount <= '0;
                  end else if (oscTick) begin
                     phaseCount <= phaseCount + 17'h0_0001;
                  end
               end
               DEV_ARRAY2: begin
                  if (advance) begin // RQ9
                     state <= DEV_ARRAY1;
                     phaseCount <= '0;
                  end else if (oscTick) begin
                     phaseCount <= phaseCount + 17'h0_0001;
                  end
               end
               default: begin
                  state <= DEV_IDLE;
                  phaseCount <= '0;
               end
            endcase
         end
      end
   end

   assign irPhase = (state == DEV_ARRAY2);

   // Up-count during array one, down-count during array two
   always_comb begin
      next_accum = accum;
      if (balancePulse && state == DEV_ARRAY1) begin
         next_accum = accum + 16'h0001; // RQ14
      end else if (balancePulse && state == DEV_ARRAY2) begin
         next_accum = accum - 16'h0001; // RQ14
      end
   end

   // Wraps past sixteen bits; an over-long interval reads wrong
   always_comb begin
      next_timer = timer;
      if (oscTick && state != DEV_IDLE) begin
         next_timer = timer + 16'h0001; // RQ11 RQ12 RQ13
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         accum <= '0;
         timer <= '0;
      end else if (state == DEV_IDLE || publish) begin
         accum <= '0;
         timer <= '0;
      end else begin
         accum <= next_accum;
         timer <= next_timer;
      end
   end

   // The pulse arriving in the closing cycle still counts
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ambientLightResult <= '0;
         intervalCycleCount <= '0;
         resultValid <= 1'b0;
      end else begin
         resultValid <= publish;
         if (publish) begin
            ambientLightResult <= next_accum; // RQ17
            intervalCycleCount <= next_timer; // RQ16
         end
      end
   end

endmodule : lsit_device

// ---- pkg/lsit_pkg.sv ----
// Shared constants and types of the light-sensor integration timing link
package lsit_pkg;

   // System clock and the conversion oscillator it is divided into
   localparam int CLK_HZ = 200_000_000;
   localparam int CLK_PERIOD_NS = 5;
   localparam int OSC_FULL_HZ = 684_000;
   localparam int OSC_HALF_HZ = 342_000;
   localparam int DIV_W = 10;
   localparam logic [DIV_W-1:0] OSC_FULL_DIV = DIV_W'(CLK_HZ / OSC_FULL_HZ);
   localparam logic [DIV_W-1:0] OSC_HALF_DIV = DIV_W'(CLK_HZ / OSC_HALF_HZ);

   // Link clock made by the host
   localparam int LINK_PERIOD_NS = 160;
   localparam int SCL_HALF_W = 5;
   localparam logic [SCL_HALF_W-1:0] SCL_HALF_CYCLES =
      SCL_HALF_W'(LINK_PERIOD_NS / CLK_PERIOD_NS / 2);

   // Frame layout: read flag, register address, data byte
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 7;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
   localparam logic [CNT_W-1:0] HDR_LAST = 5'h07;

   // Register offsets
   localparam logic [ADDR_W-1:0] REG_COMMAND = 7'h00;
   localparam logic [ADDR_W-1:0] REG_DATA_LSB = 7'h04;
   localparam logic [ADDR_W-1:0] REG_DATA_MSB = 7'h05;
   localparam logic [ADDR_W-1:0] REG_TIMER_LSB = 7'h06;
   localparam logic [ADDR_W-1:0] REG_TIMER_MSB = 7'h07;
   localparam logic [ADDR_W-1:0] REG_SYNC = 7'h08;

   // Command register fields
   localparam int CMD_WIDTH_LSB = 0;
   localparam int CMD_WIDTH_W = 2;
   localparam int CMD_RANGE_MSB = 3;
   localparam int CMD_EXT_BIT = 5;
   localparam logic [BYTE_W-1:0] CMD_RESET = 8'h00;

   // Result and cycle counts
   localparam int RESULT_W = 16;
   localparam int TIMER_W = 16;
   localparam int PHASE_W = 17;
   localparam logic [PHASE_W-1:0] CYCLES_W0 = 17'h1_0000;
   localparam logic [PHASE_W-1:0] CYCLES_W1 = 17'h0_1000;
   localparam logic [PHASE_W-1:0] CYCLES_W2 = 17'h0_0100;
   localparam logic [PHASE_W-1:0] CYCLES_W3 = 17'h0_0010;

   typedef enum logic [1:0] {
      DEV_IDLE = 2'h0,
      DEV_ARRAY1 = 2'h1,
      DEV_ARRAY2 = 2'h3
   } lsit_dev_state_type;

   typedef enum logic [2:0] {
      HST_IDLE = 3'h0,
      HST_START = 3'h1,
      HST_BITS = 3'h3,
      HST_STOP = 3'h2,
      HST_FREE = 3'h6
   } lsit_host_state_type;

endpackage : lsit_pkg

// ---- pkg/lsit_link_if.sv ----
// Two-wire link between host and sensor, with the open-drain data wire
`timescale 1ns/1ps
interface lsit_link_if;
   logic scl;
   logic sdaHostOut;
   logic sdaHostOe;
   logic sdaDevOut;
   logic sdaDevOe;
   logic sda;

   // Pulled up; any enabled driver with a low output pulls it down
   assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));

   modport host (
      output scl,
      output sdaHostOut,
      output sdaHostOe,
      input sda
   );

   modport device (
      input scl,
      input sda,
      output sdaDevOut,
      output sdaDevOe
   );
endinterface : lsit_link_if

// ---- verilog/lsit_sync.sv ----
// Two-stage synchroniser for levels entering the system clock domain
`timescale 1ns/1ps
module lsit_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         stage1 <= RESET_VAL;
         dout <= RESET_VAL;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule : lsit_sync

// ---- verilog/lsit_host.sv ----
// Host end: link master that makes the link clock and runs one frame
`timescale 1ns/1ps
module lsit_host (
   lsit_link_if.host link,
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic reqValid,
   output logic reqReady,
   input wire logic reqRead,
   input wire logic [lsit_pkg::ADDR_W-1:0] reqAddr,
   input wire logic [lsit_pkg::BYTE_W-1:0] reqData,
   output logic respValid,
   output logic [lsit_pkg::BYTE_W-1:0] respData,
   output logic respZero
);
   import lsit_pkg::*;

   lsit_host_state_type state;
   logic [SCL_HALF_W-1:0] divCount;
   logic halfTick;
   logic phase;
   logic [CNT_W-1:0] bitsLeft;
   logic [FRAME_BITS-1:0] frame;
   logic isRead;
   logic [BYTE_W-1:0] rx;
   logic sdaSync;
   logic sdaLow;

   lsit_sync #(
      .WIDTH(1),
      .RESET_VAL(1'b1)
   ) u_sdaSync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .din(link.sda),
      .dout(sdaSync)
   );

   assign reqReady = (state == HST_IDLE);
   assign halfTick = (divCount == SCL_HALF_CYCLES - 5'h01);
   assign link.sdaHostOut = 1'b0;
   assign link.sdaHostOe = sdaLow;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         divCount <= '0;
      end else if (state == HST_IDLE || halfTick) begin
         divCount <= '0;
      end else begin
         divCount <= divCount + 5'h01;
      end
   end

   // Every frame has the same length, so equally spaced sync requests
   // give equal integration intervals
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state <= HST_IDLE;
         phase <= 1'b0;
         bitsLeft <= '0;
         frame <= '0;
         isRead <= 1'b0;
         rx <= '0;
         link.scl <= 1'b1;
         sdaLow <= 1'b0;
      end else begin
         case (state)
            HST_IDLE: begin
               if (reqValid) begin // RQ7 RQ10
                  frame <= {reqRead, reqAddr, reqRead ? 8'hFF : reqData};
                  isRead <= reqRead;
                  sdaLow <= 1'b1;
                  state <= HST_START;
               end
            end
            HST_START: begin
               if (halfTick) begin
                  link.scl <= 1'b0;
                  sdaLow <= ~frame[FRAME_BITS-1];
                  bitsLeft <= FRAME_BITS;
                  phase <= 1'b0;
                  state <= HST_BITS;
               end
            end
            HST_BITS: begin
               if (halfTick && !phase) begin
                  link.scl <= 1'b1;
                  phase <= 1'b1;
               end else if (halfTick) begin
                  rx <= {rx[BYTE_W-2:0], sdaSync};
                  link.scl <= 1'b0;
                  phase <= 1'b0;
                  frame <= {frame[FRAME_BITS-2:0], 1'b1};
                  bitsLeft <= bitsLeft - 5'h01;
                  if (bitsLeft == 5'h01) begin
                     sdaLow <= 1'b1;
                     state <= HST_STOP;
                  end else begin
                     sdaLow <= ~frame[FRAME_BITS-2];
                  end
               end
            end
            HST_STOP: begin
               if (halfTick && !phase) begin
                  link.scl <= 1'b1;
                  phase <= 1'b1;
               end else if (halfTick) begin
                  sdaLow <= 1'b0;
                  phase <= 1'b0;
                  state <= HST_FREE;
               end
            end
            HST_FREE: begin
               if (halfTick) begin
                  state <= HST_IDLE;
               end
            end
            default: begin
               state <= HST_IDLE;
               link.scl <= 1'b1;
               sdaLow <= 1'b0;
            end
         endcase
      end
   end

   // Zero flag lets firmware spot a dark or saturated reading
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         respValid <= 1'b0;
         respData <= '0;
         respZero <= 1'b0;
      end else begin
         respValid <= (state == HST_FREE) & halfTick & isRead;
         if (state == HST_FREE && halfTick && isRead) begin
            respData <= rx;
            respZero <= (rx == 8'h00); // RQ15
         end
      end
   end

endmodule : lsit_host

// ---- test/lsit_link_properties.sv ----
// Checker for the two-wire link between the host and sensor ends
`timescale 1ns/1ps
module lsit_link_properties (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sdaHostOut,
   input wire logic sdaHostOe,
   input wire logic sdaDevOut,
   input wire logic sdaDevOe,
   input wire logic sda
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   logic sdaPrev;
   logic sclPrev;
   logic [4:0] fallCnt;

   // Link clock falls since the last start condition
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sdaPrev <= 1'b1;
         sclPrev <= 1'b1;
         fallCnt <= 5'h00;
      end else begin
         sdaPrev <= sda;
         sclPrev <= scl;
         if (sdaPrev && !sda && scl) begin
            fallCnt <= 5'h00;
         end else if (sclPrev && !scl) begin
            fallCnt <= fallCnt + 5'h01;
         end
      end
   end

   a_host_open_drain: assert property (sdaHostOut == 1'b0)
      else $error("host drives the data wire high");
   a_dev_open_drain: assert property (sdaDevOut == 1'b0)
      else $error("sensor drives the data wire high");
   a_clk_low_time: assert property ($fell(scl) |-> ##16 $rose(scl))
      else $error("link clock low time wrong");
   a_clk_high_time: assert property ($rose(scl) |-> scl [*8])
      else $error("link clock high time too short");
   a_start_lead: assert property
      ($rose(sdaHostOe) && scl |-> ##16 $fell(scl))
      else $error("first clock fall not 16 cycles after start");
   a_dev_change_low: assert property ($changed(sdaDevOe) |-> !scl)
      else $error("sensor changes data while link clock high");
   a_host_stable_bits: assert property
      ($changed(sdaHostOe) && scl |-> fallCnt == 5'h00 || fallCnt == 5'h11)
      else $error("host changes data while link clock high");
   a_frame_falls: assert property
      ($fell(sdaHostOe) && scl |-> fallCnt == 5'h11)
      else $error("frame without the expected clock count");
   a_dev_release: assert property
      ($rose(sdaDevOe) |-> ##[1:300] !sdaDevOe)
      else $error("sensor holds the data wire too long");

   c_start: cover property ($rose(sdaHostOe) && scl);
   c_stop: cover property ($fell(sdaHostOe) && scl);
   c_dev_reply: cover property ($rose(sdaDevOe));
endmodule : lsit_link_properties

// ---- test/light_sensor_integration_timing_tb.sv ----
// Bench: host and sensor ends facing each other across the link
`timescale 1ns/1ps
module light_sensor_integration_timing_tb;
   import lsit_pkg::*;
   localparam int LIMIT = 95000;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic balancePulse = 1'b0;
   logic reqValid = 1'b0;
   logic reqRead = 1'b0;
   logic [ADDR_W-1:0] reqAddr = 7'h00;
   logic [BYTE_W-1:0] reqData = 8'h00;
   logic reqReady;
   logic respValid;
   logic respZero;
   logic irPhase;
   logic resultValid;
   logic [BYTE_W-1:0] respData;
   logic [BYTE_W-1:0] commandValue;
   logic [RESULT_W-1:0] ambientLightResult;
   logic [TIMER_W-1:0] intervalCycleCount;
   logic [RESULT_W-1:0] cnt1 = 16'h0000;
   logic [RESULT_W-1:0] cnt2 = 16'h0000;
   logic [RESULT_W-1:0] lastExp = 16'h0000;
   logic irPrev = 1'b0;
   logic pulseOn = 1'b0;
   int bad_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int sinceFlip = 0;
   int nRes = 0;
   int lastRes = 0;
   int resGap = 0;

   lsit_link_if link ();
   lsit_host lsit_host_i (.link(link.host), .clk_sys(clk_sys), .nrst(nrst),
      .reqValid(reqValid), .reqReady(reqReady), .reqRead(reqRead),
      .reqAddr(reqAddr), .reqData(reqData), .respValid(respValid),
      .respData(respData), .respZero(respZero));
   lsit_device lsit_device_i (.link(link.device), .clk_sys(clk_sys),
      .nrst(nrst), .balancePulse(balancePulse), .irPhase(irPhase),
      .resultValid(resultValid), .ambientLightResult(ambientLightResult),
      .intervalCycleCount(intervalCycleCount), .commandValue(commandValue));
   lsit_link_properties lsit_link_properties_i (.clk_sys(clk_sys),
      .nrst(nrst), .scl(link.scl), .sdaHostOut(link.sdaHostOut),
      .sdaHostOe(link.sdaHostOe), .sdaDevOut(link.sdaDevOut),
      .sdaDevOe(link.sdaDevOe), .sda(link.sda));

   always #2.5 clk_sys = ~clk_sys;

   function automatic int int_cycles(input int w, input int div);
      return 2 * (1 << (16 - 4 * w)) * div;
   endfunction : int_cycles

   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_val

   task automatic check_range(input logic [15:0] got, input int lo,
         input int hi);
      total_checks++;
      if ($isunknown(got) || got < lo || got > hi) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h..%h", $time, got,
            lo, hi);
      end
   endtask : check_range

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report

   // Request held until taken, then wait for the host to go idle
   task automatic link_xfer(input logic isRead,
         input logic [ADDR_W-1:0] addr, input logic [BYTE_W-1:0] data);
      int n;
      n = 0;
      reqRead = isRead;
      reqAddr = addr;
      reqData = data;
      reqValid = 1'b1;
      // Ready looked at off the edge, so the taking edge is known
      while (reqReady !== 1'b1) begin
         @(posedge clk_sys);
         #1;
      end
      @(posedge clk_sys);
      #1 reqValid = 1'b0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (reqReady !== 1'b1 && n < 700);
      if (isRead) check_val(16'(respValid), 16'h0001);
   endtask : link_xfer

   // No snapshot across the two reads, so read right after a result
   task automatic read_pair(input logic [ADDR_W-1:0] addr,
         input logic [15:0] exp);
      logic [BYTE_W-1:0] lo;
      link_xfer(1'b1, addr, 8'h00);
      lo = respData;
      link_xfer(1'b1, addr + 7'h01, 8'h00);
      check_val({respData, lo}, exp);
   endtask : read_pair

   task automatic wait_res(input int n);
      int i;
      i = 0;
      while (nRes < n && i < 40000) begin
         @(posedge clk_sys);
         #1;
         i++;
      end
      check_val(16'(nRes >= n), 16'h0001);
   endtask : wait_res

   // Pulses kept clear of phase edges so both sides agree on the split
   always @(posedge clk_sys) begin
      cyc++;
      sinceFlip = (irPhase !== irPrev) ? 0 : sinceFlip + 1;
      irPrev = irPhase;
      if (resultValid === 1'b1) begin
         lastExp = cnt1 - cnt2;
         check_val(ambientLightResult, lastExp);
         cnt1 = 16'h0000;
         cnt2 = 16'h0000;
         resGap = cyc - lastRes;
         lastRes = cyc;
         nRes++;
      end
      if (balancePulse === 1'b1 && irPhase === 1'b1) cnt2 = cnt2 + 16'h0001;
      if (balancePulse === 1'b1 && irPhase === 1'b0) cnt1 = cnt1 + 16'h0001;
      if (cyc >= LIMIT) begin
         bad_count++;
         final_report();
      end
      #1 balancePulse = pulseOn && sinceFlip > 8 && sinceFlip < 2500 &&
         ($urandom % 8 == 0);
   end

   initial begin
      int d;
      int t0;
      int n0;
      int e;
      logic [BYTE_W-1:0] cmd;
      d = $urandom(32'h8ac8_3da0);
      repeat (3) @(posedge clk_sys);
      #1 nrst = 1'b1;
      link_xfer(1'b1, REG_COMMAND, 8'h00);
      check_val(16'(respData), 16'(CMD_RESET));
      check_val(16'(respZero), 16'h0001);
      for (int k = 0; k < 4; k++) begin
         link_xfer(1'b0, REG_COMMAND, 8'(k));
         link_xfer(1'b1, REG_COMMAND, 8'h00);
         check_val(16'(respData), 16'(k));
         check_val(16'(commandValue), 16'(k));
         check_val(16'(respZero), 16'(k == 0));
      end
      pulseOn = 1'b1;
      wait_res(2);
      check_val(16'(resGap), 16'(int_cycles(3, int'(OSC_HALF_DIV))));
      check_val(intervalCycleCount, 16'(2 * CYCLES_W3));
      read_pair(REG_TIMER_LSB, 16'(2 * CYCLES_W3));
      read_pair(REG_DATA_LSB, lastExp);
      cmd = {4'h0, 1'b1, 1'($urandom), 2'h3};
      link_xfer(1'b0, REG_COMMAND, cmd);
      n0 = nRes;
      wait_res(n0 + 2);
      check_val(16'(resGap), 16'(int_cycles(3, int'(OSC_FULL_DIV))));
      pulseOn = 1'b0;
      link_xfer(1'b0, REG_COMMAND, 8'h2B);
      cnt1 = 16'h0000;
      cnt2 = 16'h0000;
      n0 = nRes;
      d = 3000 + $urandom % 1000;
      t0 = cyc;
      for (int k = 0; k < 5; k++) begin
         while (cyc < t0 + k * d) begin
            @(posedge clk_sys);
            #1;
         end
         pulseOn = 1'b0;
         link_xfer(1'b0, REG_SYNC, 8'($urandom));
         pulseOn = 1'b1;
         check_val(16'(irPhase), 16'(k % 2));
         if (k == 2 || k == 4) begin
            check_val(16'(nRes - n0), 16'(k / 2));
            // Spacing d stays untouched so both intervals remain equal
            e = 2 * d / int'(OSC_FULL_DIV);
            check_range(intervalCycleCount, e - 1, e + 1);
         end
      end
      final_report();
   end
endmodule : light_sensor_integration_timing_tb
